// file: hdl/pwl_top.sv
`timescale 1ns/10ps
// Operation
// R1 - four fast channels run from one counter that counts up only or up then down.
// R2 - the counter top value is a 15-bit field.
// R3 - all fast channels share the period but each has its own compare value and polarity.
// R4 - up mode steps once per pulse clock, period is top pulse clocks, output flips at compare.
// R5 - up-down mode gives a period of twice top pulse clocks and compare time of twice compare.
// R6 - a decoder fetches duty words by memory reads and loads compares in common, grouped, individual or waveform mode.
// R7 - two duty sequences are played, repeated a set number of times or looped forever.
// R8 - four slow generators, each routed to one of three selectable pins.
// R9 - slow generator high and low widths count in 31.25 us steps from 1 to 255.
// R10 - the led controller offers on/off blinking and breathing.
// R11 - blinking repeats continuously or for 1 to 127 repetitions.
// R12 - the three blink times are 8-bit fields in 31.25 ms steps.
// R13 - breathing minimum, maximum and hold time are 8-bit fields, hold in 0.5 ms steps.
// R14 - breathing speed is a 4-bit field in 31.25 us steps.
// R15 - up counting wraps to zero after top minus one, up-down turns at top and at zero.
module pwl_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             dma_req,
  output logic      [15:0] dma_addr,
  input  wire logic        dma_ack,
  input  wire logic [15:0] dma_data,
  output logic      [3:0]  hs_pwm,
  output logic      [11:0] ls_pin,
  output logic             led_out
);
  typedef enum {D_IDLE, D_REQ} pwl_dst_t;
  typedef enum {L_IDLE, L_DLY, L_ON, L_OFF, L_UP, L_HMAX, L_DN, L_HMIN} pwl_lst_t;

  typedef struct packed {
    logic             ack;
    logic [31:0]      rdat;
    logic [31:0]      ctrl;
    logic [14:0]      top;
    logic [3:0][14:0] cmp;
    logic [31:0]      seq0;
    logic [31:0]      seq1;
    logic [7:0]       rep;
    logic [3:0][18:0] lsg;
    logic [15:0]      ledc;
    logic [31:0]      ledt;
    logic [15:0]      ledb;
    logic [7:0]       pre;
    logic [14:0]      cnt;
    logic             down;
    pwl_dst_t         dst;
    logic             sq;
    logic [15:0]      idx;
    logic [1:0]       wi;
    logic [7:0]       rleft;
    logic             fin;
    logic [15:0]      dadr;
    logic [10:0]      tick;
    logic [3:0][7:0]  gcnt;
    logic [3:0]       glvl;
    pwl_lst_t         lst;
    logic [9:0]       ucnt;
    logic [7:0]       tcnt;
    logic [6:0]       rcnt;
    logic             done;
    logic [7:0]       lvl;
    logic [7:0]       ph;
    logic [3:0]       scnt;
    logic [3:0]       hs;
    logic [11:0]      ls;
    logic             led;
  } pwl_st_t;

  pwl_st_t r;
  pwl_st_t next_r;

  function automatic logic [31:0] bmask(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] v;
    v = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) v[b*8 +: 8] = d[b*8 +: 8];
    end
    return v;
  endfunction : bmask

  // ==========================================
  // outputs
  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign dma_req  = (r.dst == D_REQ);
  assign dma_addr = r.dadr;
  assign hs_pwm   = r.hs;
  assign ls_pin   = r.ls;
  assign led_out  = r.led;

  always_comb begin
    logic        hit;
    logic        pclk;
    logic        wrap;
    logic        tk;
    logic [15:0] len;
    logic [15:0] base;
    logic [1:0]  nw;
    logic [31:0] wdat;
    logic [7:0]  w;
    logic [15:0] unit;
    logic        uend;
    logic [7:0]  tsel;
    hit  = wb_cyc_i && wb_stb_i;
    pclk = 1'b0;
    wrap = 1'b0;
    tk   = 1'b0;
    len  = '0;
    base = '0;
    nw   = '0;
    wdat = '0;
    w    = '0;
    unit = '0;
    uend = 1'b0;
    tsel = '0;
    next_r = r;

    // ==========================================
    // wishbone slave: read latched on request, write on the acked edge
    next_r.ack = hit && !r.ack;
    if (hit && !r.ack) begin
      next_r.rdat = '0;
      case (wb_adr_i)
        pwl_pkg::A_CTRL: next_r.rdat = r.ctrl;
        pwl_pkg::A_TOP:  next_r.rdat = {17'h0_0000, r.top};
        pwl_pkg::A_SEQ0: next_r.rdat = r.seq0;
        pwl_pkg::A_SEQ1: next_r.rdat = r.seq1;
        pwl_pkg::A_REP:  next_r.rdat = {24'h00_0000, r.rep};
        pwl_pkg::A_LEDC: next_r.rdat = {16'h0000, r.ledc};
        pwl_pkg::A_LEDT: next_r.rdat = r.ledt;
        pwl_pkg::A_LEDB: next_r.rdat = {16'h0000, r.ledb};
        pwl_pkg::A_STAT: begin
          next_r.rdat[14:0]               = r.cnt;
          next_r.rdat[pwl_pkg::S_BUSY]    = (r.dst == D_REQ);
          next_r.rdat[pwl_pkg::S_FIN]     = r.fin;
          next_r.rdat[pwl_pkg::S_SEQ]     = r.sq;
          next_r.rdat[pwl_pkg::S_LED]     = r.led;
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_adr_i == pwl_pkg::A_CMP + 8'(4 * i)) next_r.rdat = {17'h0_0000, r.cmp[i]};
            if (wb_adr_i == pwl_pkg::A_LSG + 8'(4 * i)) next_r.rdat = {13'h0000, r.lsg[i]};
          end
        end
      endcase
    end
    if (hit && r.ack && wb_we_i) begin
      case (wb_adr_i)
        pwl_pkg::A_CTRL: next_r.ctrl = bmask(r.ctrl, wb_dat_i, wb_sel_i);
        // R2 top field
        pwl_pkg::A_TOP: begin
          wdat       = bmask({17'h0_0000, r.top}, wb_dat_i, wb_sel_i);
          next_r.top = wdat[14:0];
        end
        pwl_pkg::A_SEQ0: next_r.seq0 = bmask(r.seq0, wb_dat_i, wb_sel_i);
        pwl_pkg::A_SEQ1: next_r.seq1 = bmask(r.seq1, wb_dat_i, wb_sel_i);
        pwl_pkg::A_REP:  if (wb_sel_i[0]) next_r.rep = wb_dat_i[7:0];
        pwl_pkg::A_LEDC: begin
          wdat        = bmask({16'h0000, r.ledc}, wb_dat_i, wb_sel_i);
          next_r.ledc = wdat[15:0];
        end
        pwl_pkg::A_LEDT: next_r.ledt = bmask(r.ledt, wb_dat_i, wb_sel_i);
        pwl_pkg::A_LEDB: begin
          wdat        = bmask({16'h0000, r.ledb}, wb_dat_i, wb_sel_i);
          next_r.ledb = wdat[15:0];
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_adr_i == pwl_pkg::A_CMP + 8'(4 * i)) begin
              wdat          = bmask({17'h0_0000, r.cmp[i]}, wb_dat_i, wb_sel_i);
              next_r.cmp[i] = wdat[14:0];
            end
            if (wb_adr_i == pwl_pkg::A_LSG + 8'(4 * i)) begin
              wdat          = bmask({13'h0000, r.lsg[i]}, wb_dat_i, wb_sel_i);
              next_r.lsg[i] = wdat[18:0];
            end
          end
        end
      endcase
    end

    // ==========================================
    // fast counter
    pclk = (r.pre >= r.ctrl[pwl_pkg::C_PRE +: 8]);
    next_r.pre = pclk ? 8'h00 : r.pre + 8'h01;
    if (!r.ctrl[pwl_pkg::C_EN]) begin
      next_r.cnt  = '0;
      next_r.down = 1'b0;
      next_r.pre  = '0;
    end else if (pclk) begin
      if (!r.ctrl[pwl_pkg::C_UD]) begin
        // R4 one step per pulse clock
        // R15 wrap after top minus one
        wrap        = ({1'b0, r.cnt} + 16'h0001 >= {1'b0, r.top});
        next_r.cnt  = wrap ? 15'h0000 : r.cnt + 15'h0001;
        next_r.down = 1'b0;
      end else if (!r.down) begin
        // R5 up leg of up-down
        // R15 turn at top
        if (r.cnt + 15'h0001 >= r.top) next_r.down = 1'b1;
        next_r.cnt = r.cnt + 15'h0001;
      end else begin
        // R15 turn at zero
        wrap       = (r.cnt <= 15'h0001);
        next_r.cnt = r.cnt - 15'h0001;
        if (wrap) next_r.down = 1'b0;
      end
    end
    // R1 four channels from one counter
    // R3 own compare and polarity
    // R5 strict compare on down leg
    for (int i = 0; i < 4; i++) begin
      next_r.hs[i] = (r.ctrl[pwl_pkg::C_EN] && (r.down ? r.cnt > r.cmp[i] : r.cnt >= r.cmp[i]))
                     ^ r.ctrl[pwl_pkg::C_POL + i];
    end

    // ==========================================
    // duty decoder
    len  = r.sq ? r.seq1[pwl_pkg::Q_LEN +: 16] : r.seq0[pwl_pkg::Q_LEN +: 16];
    base = r.sq ? r.seq1[pwl_pkg::Q_BASE +: 16] : r.seq0[pwl_pkg::Q_BASE +: 16];
    case (pwl_pkg::pwl_dmode_t'(r.ctrl[pwl_pkg::C_DMODE +: 2]))
      pwl_pkg::DM_COMMON: nw = 2'd0;
      pwl_pkg::DM_GROUP:  nw = 2'd1;
      default:            nw = 2'd3;
    endcase
    if (!r.ctrl[pwl_pkg::C_DEN]) begin
      next_r.dst   = D_IDLE;
      next_r.sq    = 1'b0;
      next_r.idx   = '0;
      next_r.fin   = 1'b0;
      next_r.rleft = r.rep;
    end else begin
      case (r.dst)
        D_IDLE: begin
          // R6 fetch on each period start
          if (wrap && !r.fin && len != 16'h0000) begin
            next_r.dst  = D_REQ;
            next_r.wi   = '0;
            next_r.dadr = base + r.idx;
          end
        end
        D_REQ: begin
          if (dma_ack) begin
            // R6 route by mode
            case (pwl_pkg::pwl_dmode_t'(r.ctrl[pwl_pkg::C_DMODE +: 2]))
              pwl_pkg::DM_COMMON: for (int i = 0; i < 4; i++) next_r.cmp[i] = dma_data[14:0];
              pwl_pkg::DM_GROUP: begin
                next_r.cmp[{r.wi[0], 1'b0}] = dma_data[14:0];
                next_r.cmp[{r.wi[0], 1'b1}] = dma_data[14:0];
              end
              pwl_pkg::DM_INDIV: next_r.cmp[r.wi] = dma_data[14:0];
              default: begin
                if (r.wi == 2'd3) next_r.top = dma_data[14:0];
                else next_r.cmp[r.wi] = dma_data[14:0];
              end
            endcase
            next_r.idx = r.idx + 16'h0001;
            if (r.idx + 16'h0001 >= len) begin
              // R7 alternate sequences, loop or count repeats
              next_r.idx = '0;
              next_r.sq  = ~r.sq;
              if (r.sq && !r.ctrl[pwl_pkg::C_LOOP]) begin
                if (r.rleft == 8'h00) next_r.fin = 1'b1;
                else next_r.rleft = r.rleft - 8'h01;
              end
            end
            next_r.wi   = r.wi + 2'd1;
            next_r.dadr = base + r.idx + 16'h0001;
            if (r.wi == nw || (r.idx + 16'h0001 >= len)) next_r.dst = D_IDLE;
          end
        end
        default: next_r.dst = D_IDLE;
      endcase
    end

    // ==========================================
    // low-speed generators
    tk = (r.tick >= 11'(pwl_pkg::TICK_CYC - 1));
    next_r.tick = tk ? 11'h000 : r.tick + 11'h001;
    for (int i = 0; i < 4; i++) begin
      w = r.glvl[i] ? r.lsg[i][pwl_pkg::G_HI +: 8] : r.lsg[i][pwl_pkg::G_LO +: 8];
      if (!r.lsg[i][pwl_pkg::G_EN]) begin
        next_r.gcnt[i] = '0;
        next_r.glvl[i] = 1'b1;
      end else if (tk) begin
        // R9 width in 31.25 us steps, zero acts as one
        if (r.gcnt[i] + 8'h01 >= w) begin
          next_r.gcnt[i] = '0;
          next_r.glvl[i] = ~r.glvl[i];
        end else begin
          next_r.gcnt[i] = r.gcnt[i] + 8'h01;
        end
      end
      // R8 route to one of three pins
      for (int k = 0; k < 3; k++) begin
        next_r.ls[i*3 + k] = r.lsg[i][pwl_pkg::G_EN] && r.glvl[i] && (r.lsg[i][pwl_pkg::G_SEL +: 2] == 2'(k));
      end
    end

    // ==========================================
    // led controller
    // R12 blink unit 31.25 ms
    // R13 breath hold unit 0.5 ms
    unit = (r.lst == L_HMAX || r.lst == L_HMIN) ? 16'(pwl_pkg::BREATH_TICKS) : 16'(pwl_pkg::BLINK_TICKS);
    uend = tk && ({6'h00, r.ucnt} + 16'h0001 >= unit);
    if (tk) next_r.ucnt = uend ? 10'h000 : r.ucnt + 10'h001;
    if (uend) next_r.tcnt = r.tcnt + 8'h01;
    if (tk) next_r.ph = r.ph + 8'h01;
    if (!r.ledc[pwl_pkg::E_EN]) begin
      next_r.lst  = L_IDLE;
      next_r.done = 1'b0;
    end
    case (r.lst)
      L_IDLE: begin
        next_r.ucnt = '0;
        next_r.tcnt = '0;
        next_r.rcnt = '0;
        next_r.lvl  = r.ledb[pwl_pkg::B_MIN +: 8];
        // R10 pick blinking or breathing
        if (r.ledc[pwl_pkg::E_EN] && !r.done) next_r.lst = r.ledc[pwl_pkg::E_BR] ? L_UP : L_DLY;
      end
      L_DLY, L_ON, L_OFF, L_HMAX, L_HMIN: begin
        case (r.lst)
          L_DLY:   tsel = r.ledt[pwl_pkg::T_3 +: 8];
          L_ON:    tsel = r.ledt[pwl_pkg::T_1 +: 8];
          L_OFF:   tsel = r.ledt[pwl_pkg::T_2 +: 8];
          default: tsel = r.ledt[pwl_pkg::T_4 +: 8];
        endcase
        if (r.ledc[pwl_pkg::E_EN] && (r.tcnt >= tsel)) begin
          next_r.tcnt = '0;
          next_r.ucnt = '0;
          case (r.lst)
            L_DLY:  next_r.lst = L_ON;
            L_ON:   next_r.lst = L_OFF;
            L_HMAX: next_r.lst = L_DN;
            L_HMIN: next_r.lst = L_UP;
            default: begin
              // R11 zero count repeats forever
              next_r.rcnt = r.rcnt + 7'h01;
              if (r.ledc[pwl_pkg::E_REP +: 7] != 7'h00 && r.rcnt + 7'h01 >= r.ledc[pwl_pkg::E_REP +: 7]) begin
                next_r.lst  = L_IDLE;
                next_r.done = 1'b1;
              end else begin
                next_r.lst = L_ON;
              end
            end
          endcase
        end
      end
      L_UP, L_DN: begin
        // R14 level step every speed ticks
        if (tk) next_r.scnt = r.scnt + 4'h1;
        if (tk && r.scnt + 4'h1 >= r.ledc[pwl_pkg::E_SP +: 4]) begin
          next_r.scnt = '0;
          if (r.lst == L_UP) begin
            if (r.lvl >= r.ledb[pwl_pkg::B_MAX +: 8]) next_r.lst = L_HMAX;
            else next_r.lvl = r.lvl + 8'h01;
          end else begin
            if (r.lvl <= r.ledb[pwl_pkg::B_MIN +: 8]) next_r.lst = L_HMIN;
            else next_r.lvl = r.lvl - 8'h01;
          end
          next_r.tcnt = '0;
          next_r.ucnt = '0;
        end
      end
      default: next_r.lst = L_IDLE;
    endcase
    case (r.lst)
      L_ON:                         next_r.led = 1'b1;
      L_UP, L_DN, L_HMAX, L_HMIN:   next_r.led = (r.ph < r.lvl);
      default:                      next_r.led = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r      <= '0;
      r.ctrl <= pwl_pkg::CTRL_RST;
      r.top  <= pwl_pkg::TOP_RST;
      r.glvl <= 4'hF;
      r.dst  <= D_IDLE;
      r.lst  <= L_IDLE;
    end else begin
      r <= next_r;
    end
  end
endmodule : pwl_top

// file: hdl/pwl_pkg.sv
package pwl_pkg;
  // ==========================================
  // clock and low-speed time base
  localparam int CLK_HZ       = 50_000_000;
  localparam int TICK_NS      = 31_250;
  localparam int TICK_CYC     = (TICK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BLINK_NS     = 31_250_000;
  localparam int BLINK_TICKS  = BLINK_NS / TICK_NS;
  localparam int BREATH_NS    = 500_000;
  localparam int BREATH_TICKS = BREATH_NS / TICK_NS;

  // ==========================================
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TOP  = 8'h04;
  localparam logic [7:0] A_CMP  = 8'h08;
  localparam logic [7:0] A_SEQ0 = 8'h18;
  localparam logic [7:0] A_SEQ1 = 8'h1C;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_REP  = 8'h24;
  localparam logic [7:0] A_LSG  = 8'h28;
  localparam logic [7:0] A_LEDC = 8'h38;
  localparam logic [7:0] A_LEDT = 8'h3C;
  localparam logic [7:0] A_LEDB = 8'h40;

  // ==========================================
  // field positions
  localparam int C_EN = 0;
  localparam int C_UD = 1;
  localparam int C_POL = 2;
  localparam int C_DMODE = 6;
  localparam int C_DEN = 8;
  localparam int C_LOOP = 9;
  localparam int C_PRE = 16;
  localparam int Q_BASE = 0;
  localparam int Q_LEN = 16;
  localparam int G_HI = 0;
  localparam int G_LO = 8;
  localparam int G_SEL = 16;
  localparam int G_EN = 18;
  localparam int E_EN = 0;
  localparam int E_BR = 1;
  localparam int E_REP = 2;
  localparam int E_SP = 12;
  localparam int T_1 = 0;
  localparam int T_2 = 8;
  localparam int T_3 = 16;
  localparam int T_4 = 24;
  localparam int B_MIN = 0;
  localparam int B_MAX = 8;
  localparam int S_BUSY = 16;
  localparam int S_FIN = 17;
  localparam int S_SEQ = 18;
  localparam int S_LED = 19;

  // ==========================================
  // reset values and modes
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [14:0] TOP_RST  = 15'h00FF;
  typedef enum logic [1:0] {DM_COMMON, DM_GROUP, DM_INDIV, DM_WAVE} pwl_dmode_t;
endpackage : pwl_pkg

// file: verif/pwl_checker.sv
`timescale 1ns/10ps
module pwl_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        dma_req,
  input wire logic [15:0] dma_addr,
  input wire logic        dma_ack,
  input wire logic [15:0] dma_data,
  input wire logic [3:0]  hs_pwm,
  input wire logic [11:0] ls_pin,
  input wire logic        led_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ==========================================
  // slow pin spacing helpers
  logic [11:0] gap;
  logic [3:0]  wr_age;
  logic        clean;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap    <= '0;
      wr_age <= '0;
      clean  <= 1'b0;
    end else begin
      gap    <= $changed(ls_pin[2:0]) ? 12'h000 : gap + {11'h000, ~&gap};
      wr_age <= (wb_cyc_i && wb_we_i) ? 4'h0 : wr_age + {3'h0, ~&wr_age};
      clean  <= (wb_cyc_i && wb_we_i) ? 1'b0 : ($changed(ls_pin[2:0]) ? (wr_age > 4'h4) : clean);
    end
  end

  // ==========================================
  // assertions
  ack_once_a:
    assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
  ack_time_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
  ack_cause_a:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
  top_width_a:
    assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == pwl_pkg::A_TOP |-> wb_dat_o[31:15] == 17'h00000)
      else $error("top value wider than 15 bits");
  dma_hold_a:
    assert property (dma_req && !dma_ack && !(wb_cyc_i && wb_we_i) && !$past(wb_cyc_i && wb_we_i)
                     |=> dma_req && $stable(dma_addr))
      else $error("memory request dropped or moved before answer");
  dma_step_a:
    assert property ($past(dma_req) && $past(dma_ack) && dma_req |-> dma_addr == $past(dma_addr) + 16'h0001)
      else $error("duty word address did not advance");
  slow_route_a:
    assert property ($onehot0(ls_pin[2:0]) && $onehot0(ls_pin[5:3]) && $onehot0(ls_pin[8:6]) && $onehot0(ls_pin[11:9]))
      else $error("slow generator drives more than one pin");
  slow_width_a:
    assert property ($changed(ls_pin[2:0]) && clean && wr_age > 4'h4 |-> gap >= 12'd1562)
      else $error("slow pulse shorter than one step");

  cover property (dma_req && dma_ack);
  cover property (wb_ack_o && $past(wb_we_i));
  cover property ($rose(hs_pwm[0]));
  cover property ($changed(ls_pin));
endmodule : pwl_checker

bind pwl_top pwl_checker pwl_checker_i (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .dma_req, .dma_addr, .dma_ack, .dma_data, .hs_pwm, .ls_pin, .led_out);

// file: verif/pwl_mem_model.sv
`timescale 1ns/10ps
module pwl_mem_model (
  input  wire logic        clk,
  input  wire logic        dma_req,
  input  wire logic [15:0] dma_addr,
  input  wire logic [3:0]  wait_cyc,
  output logic             dma_ack,
  output logic      [15:0] dma_data
);
  logic [3:0] cnt = 4'h0;
  // ==========================================
  // data memory answering duty word fetches
  always @(posedge clk) begin
    dma_ack  <= 1'b0;
    dma_data <= ~dma_data;
    if (dma_req && !dma_ack) begin
      if (cnt >= wait_cyc) begin
        cnt      <= 4'h0;
        dma_ack  <= 1'b1;
        dma_data <= {8'h00, dma_addr[7:0]};
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : pwl_mem_model

// file: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clk;
  logic        reset_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        dma_req;
  logic [15:0] dma_addr;
  logic        dma_ack;
  logic [15:0] dma_data;
  logic [3:0]  hs_pwm;
  logic [11:0] ls_pin;
  logic        led_out;
  logic [3:0]  mem_wait;
  int          errors;
  int          check_count;
  int          acks;
  localparam int EXP_UP [4] = '{70, 80, 100, 0};
  localparam int TOPS [4] = '{32, 32, 32, 23};
  localparam int CMPS [4][4] = '{'{23, 23, 23, 23}, '{22, 22, 23, 23}, '{20, 21, 22, 23}, '{20, 21, 22, 23}};

  pwl_top pwl_top_i (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dma_req(dma_req), .dma_addr(dma_addr), .dma_ack(dma_ack), .dma_data(dma_data), .hs_pwm(hs_pwm),
    .ls_pin(ls_pin), .led_out(led_out));
  pwl_mem_model pwl_mem_model_i (.clk(clk), .dma_req(dma_req), .dma_addr(dma_addr), .wait_cyc(mem_wait),
    .dma_ack(dma_ack), .dma_data(dma_data));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dma_req === 1'b1 && dma_ack === 1'b1) acks++;
  end

  // ==========================================
  // common tasks
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic timeout(input string s);
    errors++;
    $display("unexpected wait in %s expected done seen still waiting", s);
    final_report();
  endtask : timeout
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) timeout("bus");
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd_chk(input string s, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb_xfer(1'b0, a, 32'h0, r);
    chk(s, e, r);
  endtask : rd_chk
  task automatic duty(input int n, output int hi [4]);
    hi = '{0, 0, 0, 0};
    repeat (n) begin
      @(posedge clk);
      for (int i = 0; i < 4; i++) hi[i] += (hs_pwm[i] === 1'b1);
    end
  endtask : duty
  task automatic lvl(input int i, input logic v, output int n);
    n = 0;
    while (ls_pin[i] !== v) begin
      @(posedge clk);
      n++;
      if (n > 20000) timeout("slow pin");
    end
  endtask : lvl

  // ==========================================
  // scenarios
  task automatic t_regs();
    rd_chk("top reset", pwl_pkg::A_TOP, 32'h0000_00FF);
    wr(pwl_pkg::A_TOP, 32'hFFFF_FFFF);
    rd_chk("top width", pwl_pkg::A_TOP, 32'h0000_7FFF);
    rd_chk("unmapped read", 8'hFC, 32'h0000_0000);
    wr(pwl_pkg::A_LEDT, 32'hA5C3_7E81);
    rd_chk("blink times", pwl_pkg::A_LEDT, 32'hA5C3_7E81);
    wr(pwl_pkg::A_LEDB, 32'hFFFF_FFFF);
    rd_chk("breath levels", pwl_pkg::A_LEDB, 32'h0000_FFFF);
    wr(pwl_pkg::A_LEDC, 32'h0000_F000);
    rd_chk("breath speed", pwl_pkg::A_LEDC, 32'h0000_F000);
  endtask : t_regs
  task automatic t_fast();
    int hi [4];
    int m;
    wr(pwl_pkg::A_TOP, 32'h0000_000A);
    wr(pwl_pkg::A_CMP, 32'h0000_0003);
    wr(pwl_pkg::A_CMP + 8'h04, 32'h0000_0008);
    wr(pwl_pkg::A_CMP + 8'h08, 32'h0000_0000);
    wr(pwl_pkg::A_CMP + 8'h0C, 32'h0000_000A);
    for (int k = 0; k < 4; k++) begin
      m = (k % 2 + 1) * (k / 2 + 1);
      wr(pwl_pkg::A_CTRL, 32'h0000_0009 | (32'(k % 2) << 16) | (32'(k / 2) << 1));
      repeat (20 * m) @(posedge clk);
      duty(100 * m, hi);
      for (int i = 0; i < 4; i++) chk("fast duty", 32'(EXP_UP[i] * m), 32'(hi[i]));
    end
  endtask : t_fast
  task automatic t_dec();
    int hi [4];
    int n;
    logic [31:0] r;
    for (int md = 0; md < 4; md++) begin
      wr(pwl_pkg::A_CTRL, 32'h0000_0000);
      mem_wait <= 4'(3 - md);
      wr(pwl_pkg::A_TOP, 32'h0000_0020);
      wr(pwl_pkg::A_SEQ0, 32'h0004_0010);
      wr(pwl_pkg::A_SEQ1, 32'h0004_0014);
      wr(pwl_pkg::A_REP, 32'h0000_0001);
      acks = 0;
      wr(pwl_pkg::A_CTRL, 32'h0000_0101 | (32'(md) << 6));
      n = 0;
      do begin
        repeat (50) @(posedge clk);
        wb_xfer(1'b0, pwl_pkg::A_STAT, 32'h0, r);
        n++;
        if (n > 100) timeout("decoder");
      end while (r[pwl_pkg::S_FIN] !== 1'b1);
      chk("duty words fetched", 32'h0000_0010, 32'(acks));
      repeat (64) @(posedge clk);
      duty(10 * TOPS[md], hi);
      for (int i = 0; i < 4; i++) chk("decoded duty", 32'(10 * (TOPS[md] - CMPS[md][i])), 32'(hi[i]));
    end
    acks = 0;
    wr(pwl_pkg::A_CTRL, 32'h0000_0000);
    wr(pwl_pkg::A_TOP, 32'h0000_0020);
    wr(pwl_pkg::A_CTRL, 32'h0000_0301);
    repeat (1500) @(posedge clk);
    wb_xfer(1'b0, pwl_pkg::A_STAT, 32'h0, r);
    chk("looping not finished", 32'h0, 32'(r[pwl_pkg::S_FIN]));
    chk("looping keeps fetching", 32'h1, 32'(acks > 16));
    wr(pwl_pkg::A_CTRL, 32'h0000_0000);
  endtask : t_dec
  task automatic t_slow(input int g, input logic [31:0] cfg, input int eh, input int el);
    int n;
    int h;
    int l;
    wr(pwl_pkg::A_LSG + 8'(4 * g), cfg);
    lvl(g * 3 + 32'(cfg[17:16]), 1'b1, n);
    lvl(g * 3 + 32'(cfg[17:16]), 1'b0, n);
    lvl(g * 3 + 32'(cfg[17:16]), 1'b1, l);
    lvl(g * 3 + 32'(cfg[17:16]), 1'b0, h);
    chk("slow high width", 32'(eh * pwl_pkg::TICK_CYC), 32'(h));
    chk("slow low width", 32'(el * pwl_pkg::TICK_CYC), 32'(l));
    wr(pwl_pkg::A_LSG + 8'(4 * g), 32'h0000_0000);
  endtask : t_slow
  task automatic t_led(input logic [31:0] ctl, input logic [31:0] tim, input logic [31:0] lev, input int e);
    int n;
    n = 0;
    wr(pwl_pkg::A_LEDB, lev);
    wr(pwl_pkg::A_LEDT, tim);
    wr(pwl_pkg::A_LEDC, ctl);
    repeat (3000) begin
      @(posedge clk);
      n += (led_out === 1'b1);
    end
    chk("led on cycles", 32'(e), 32'(n));
    wr(pwl_pkg::A_LEDC, 32'h0000_0000);
  endtask : t_led

  initial begin
    reset_n  = 1'b0;
    wb_cyc   = 1'b0;
    wb_stb   = 1'b0;
    wb_we    = 1'b0;
    wb_adr   = 8'h00;
    wb_sel   = 4'h0;
    wb_dat   = 32'h0;
    mem_wait = 4'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_fast();
    t_dec();
    t_slow(0, 32'h0005_0302, 2, 3);
    t_slow(3, 32'h0006_0101, 1, 1);
    t_led(32'h0000_1003, 32'h0000_0000, 32'h0000_FFFF, 2998);
    t_led(32'h0000_0001, 32'h0000_0001, 32'h0000_0000, 2997);
    final_report();
  end
  initial begin
    repeat (90000) @(posedge clk);
    timeout("whole run");
  end
endmodule : tb_top
